// File: sdm_defs.vh
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH

// ==========================================================
// Period and sub-cycle lengths in system clocks
// ==========================================================
`define SDM_PERIOD_CLKS   256
`define SDM_SUB4_CLKS     64
`define SDM_SUB2_CLKS     128
`define SDM_PHASE_LAST    8'hFF
`define SDM_PHASE_FIRST   8'h00

// ==========================================================
// Subdivision mode option codes
// ==========================================================
`define SDM_MODE_SUB4     1
`define SDM_MODE_SUB2     0

// ==========================================================
// Channel count options
// ==========================================================
`define SDM_CH_MAX        4
`define SDM_CH_SMALL_PKG  3

// ==========================================================
// Duty field positions, four-sub-cycle mode
// ==========================================================
`define SDM_S4_COARSE_MSB 7
`define SDM_S4_COARSE_LSB 2
`define SDM_S4_FINE_MSB   1
`define SDM_S4_FINE_LSB   0
`define SDM_S4_POS_MSB    5
`define SDM_S4_SUB_MSB    7
`define SDM_S4_SUB_LSB    6

// ==========================================================
// Duty field positions, two-sub-cycle mode
// ==========================================================
`define SDM_S2_COARSE_MSB 7
`define SDM_S2_COARSE_LSB 1
`define SDM_S2_FINE_BIT   0
`define SDM_S2_POS_MSB    6
`define SDM_S2_SUB_BIT    7

// ==========================================================
// Reset values
// ==========================================================
`define SDM_DUTY_RST      8'h00
`define SDM_PHASE_RST     8'h00

`endif

// File: sdm_chan.v
`timescale 1ns/1ps
`include "sdm_defs.vh"

module sdm_chan #(
   parameter SUB4 = `SDM_MODE_SUB4
) (
   input  wire [7:0] phase,
   input  wire [7:0] duty,
   output wire       level
);

   // ==========================================================
   // Per sub-cycle high-time compare
   // ==========================================================
   generate
      if (SUB4 == `SDM_MODE_SUB4) begin : g_sub4
         wire [5:0] coarse;
         wire [1:0] fine;
         wire [1:0] sub_idx;
         wire [6:0] thr;
         assign coarse  = duty[`SDM_S4_COARSE_MSB:`SDM_S4_COARSE_LSB];
         assign fine    = duty[`SDM_S4_FINE_MSB:`SDM_S4_FINE_LSB];
         assign sub_idx = phase[`SDM_S4_SUB_MSB:`SDM_S4_SUB_LSB];
         // Extra clock only in the first 'fine' sub-cycles
         assign thr     = {1'b0, coarse} + {6'h00, (sub_idx < fine)};
         // High portion leads each sub-cycle
         assign level   = ({1'b0, phase[`SDM_S4_POS_MSB:0]} < thr);
      end else begin : g_sub2
         wire [6:0] coarse;
         wire       fine;
         wire       sub_idx;
         wire [7:0] thr;
         assign coarse  = duty[`SDM_S2_COARSE_MSB:`SDM_S2_COARSE_LSB];
         assign fine    = duty[`SDM_S2_FINE_BIT];
         assign sub_idx = phase[`SDM_S2_SUB_BIT];
         assign thr     = {1'b0, coarse} + {7'h00, (!sub_idx && fine)};
         assign level   = ({1'b0, phase[`SDM_S2_POS_MSB:0]} < thr);
      end
   endgenerate

endmodule // sdm_chan

// File: sdm_modulator.v
`timescale 1ns/1ps
`include "sdm_defs.vh"

module sdm_modulator #(
   parameter NUM_CH   = `SDM_CH_MAX,
   parameter SUB4     = `SDM_MODE_SUB4,
   parameter PWM_OPT  = 1,
   parameter PULL_OPT = 4'hF
) (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       dm_wr_en,
   input  wire [1:0] dm_wr_sel,
   input  wire [7:0] dm_wr_data,
   input  wire [1:0] dm_rd_sel,
   output reg  [7:0] dm_rd_data,
   input  wire [3:0] port_d_direction,
   input  wire [3:0] port_d_output_latch,
   input  wire [3:0] shared_pin_in,
   output reg  [3:0] shared_pin_out,
   output reg  [3:0] shared_pin_oe,
   output reg  [3:0] shared_pin_pull,
   output reg  [3:0] port_d_read,
   output reg  [3:0] duty_pending,
   output reg        period_start
);

   // ==========================================================
   // Local widths and derived constants
   // ==========================================================
   localparam [7:0] LAST_PH  = `SDM_PHASE_LAST;
   localparam [7:0] FIRST_PH = `SDM_PHASE_FIRST;
   localparam [3:0] PULL_EN  = PULL_OPT;
   localparam       CH_MAX   = `SDM_CH_MAX;

   // Per-pin role, decoded once and shared by drive and read-back
   localparam [1:0] PIN_INPUT = 2'h0;
   localparam [1:0] PIN_WAVE  = 2'h1;
   localparam [1:0] PIN_PLAIN = 2'h2;

   // ==========================================================
   // Signal declarations
   // ==========================================================
   reg  [7:0] phase_reg;
   wire [7:0] phase_next;
   wire       period_end;

   reg  [7:0] duty_reg    [0:CH_MAX-1];
   reg  [7:0] active_reg  [0:CH_MAX-1];
   reg  [3:0] pending_reg;
   reg  [3:0] pending_next;

   wire [3:0] ch_present;
   wire [3:0] ch_wave;
   wire [3:0] wr_hit;

   reg  [3:0] pin_out_next;
   reg  [3:0] pin_oe_next;
   reg  [3:0] pin_pull_next;
   reg  [3:0] port_rd_next;
   reg  [7:0] rd_data_next;
   reg  [7:0] pin_mode;

   integer k;

   // ==========================================================
   // Period phase counter
   // ==========================================================
   // Sole timebase is mclk itself, no prescale stage
   assign phase_next = phase_reg + 8'h01;

   // An 8-bit wrap gives exactly the full period length
   assign period_end = (phase_reg == LAST_PH);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= `SDM_PHASE_RST;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // Marks the first clock of a period on the pins
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         period_start <= 1'b0;
      end else begin
         period_start <= (phase_reg == FIRST_PH);
      end
   end

   // ==========================================================
   // Channel population and write decode
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < CH_MAX; g = g + 1) begin : g_present
         // Small package leaves the last channel off
         assign ch_present[g] = (g < NUM_CH);
         assign wr_hit[g]     = dm_wr_en && (dm_wr_sel == g)
                                && ch_present[g];
      end
   endgenerate

   // ==========================================================
   // Duty registers in data memory
   // ==========================================================
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < CH_MAX; k = k + 1) begin
            duty_reg[k] <= `SDM_DUTY_RST;
         end
      end else begin
         for (k = 0; k < CH_MAX; k = k + 1) begin
            if (wr_hit[k]) begin
               duty_reg[k] <= dm_wr_data;
            end
         end
      end
   end

   // ==========================================================
   // Period-boundary duty transfer
   // ==========================================================
   // Taking the value only at the wrap keeps a period consistent;
   // cost is up to one full period of latency after a write.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < CH_MAX; k = k + 1) begin
            active_reg[k] <= `SDM_DUTY_RST;
         end
      end else begin
         for (k = 0; k < CH_MAX; k = k + 1) begin
            if (period_end) begin
               active_reg[k] <= duty_reg[k];
            end
         end
      end
   end

   // Pending flag: a write in the transfer cycle stays pending
   always @* begin
      pending_next = pending_reg;
      for (k = 0; k < CH_MAX; k = k + 1) begin
         if (wr_hit[k]) begin
            pending_next[k] = 1'b1;
         end else if (period_end) begin
            pending_next[k] = 1'b0;
         end
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pending_reg  <= 4'h0;
         duty_pending <= 4'h0;
      end else begin
         pending_reg  <= pending_next;
         duty_pending <= pending_next;
      end
   end

   // ==========================================================
   // Waveform generators
   // ==========================================================
   // Mode is one build option passed to every channel alike
   generate
      for (g = 0; g < CH_MAX; g = g + 1) begin : g_chan
         sdm_chan #(
            .SUB4  (SUB4)
         ) u_chan (
            .phase (phase_reg),
            .duty  (active_reg[g]),
            .level (ch_wave[g])
         );
      end
   endgenerate

   // ==========================================================
   // Shared pin role decode
   // ==========================================================
   // Pins without a channel, or with the option off, are plain I/O.
   // Direction bit is owned by software; zero means output.
   always @* begin
      pin_mode = 8'h00;
      for (k = 0; k < CH_MAX; k = k + 1) begin
         if (port_d_direction[k]) begin
            // Input even with the modulator option chosen
            pin_mode[2*k +: 2] = PIN_INPUT;
         end else if ((PWM_OPT != 0) && ch_present[k]) begin
            pin_mode[2*k +: 2] = PIN_WAVE;
         end else begin
            pin_mode[2*k +: 2] = PIN_PLAIN;
         end
      end
   end

   // ==========================================================
   // Shared pin drive enable
   // ==========================================================
   always @* begin
      pin_oe_next = 4'h0;
      for (k = 0; k < CH_MAX; k = k + 1) begin
         case (pin_mode[2*k +: 2])
            PIN_INPUT: begin
               pin_oe_next[k] = 1'b0;
            end
            PIN_WAVE: begin
               pin_oe_next[k] = 1'b1;
            end
            PIN_PLAIN: begin
               pin_oe_next[k] = 1'b1;
            end
            default: begin
               pin_oe_next[k] = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Shared pin pull-high
   // ==========================================================
   always @* begin
      pin_pull_next = 4'h0;
      for (k = 0; k < CH_MAX; k = k + 1) begin
         case (pin_mode[2*k +: 2])
            PIN_INPUT: begin
               pin_pull_next[k] = PULL_EN[k];
            end
            PIN_WAVE: begin
               pin_pull_next[k] = 1'b0;
            end
            PIN_PLAIN: begin
               pin_pull_next[k] = 1'b0;
            end
            default: begin
               pin_pull_next[k] = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Shared pin drive value
   // ==========================================================
   always @* begin
      pin_out_next = 4'h0;
      for (k = 0; k < CH_MAX; k = k + 1) begin
         case (pin_mode[2*k +: 2])
            PIN_INPUT: begin
               pin_out_next[k] = 1'b0;
            end
            PIN_WAVE: begin
               // Latch acts as on/off gate for the waveform
               pin_out_next[k] = port_d_output_latch[k] & ch_wave[k];
            end
            PIN_PLAIN: begin
               pin_out_next[k] = port_d_output_latch[k];
            end
            default: begin
               pin_out_next[k] = 1'b0;
            end
         endcase
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shared_pin_out  <= 4'h0;
         shared_pin_oe   <= 4'h0;
         shared_pin_pull <= 4'h0;
      end else begin
         shared_pin_out  <= pin_out_next;
         shared_pin_oe   <= pin_oe_next;
         shared_pin_pull <= pin_pull_next;
      end
   end

   // ==========================================================
   // Port read-back
   // ==========================================================
   // Input pins read the pad; output pins read the latch so that
   // read-modify-write bit operations keep the latch intact.
   always @* begin
      port_rd_next = 4'h0;
      for (k = 0; k < CH_MAX; k = k + 1) begin
         if (pin_mode[2*k +: 2] == PIN_INPUT) begin
            port_rd_next[k] = shared_pin_in[k];
         end else begin
            port_rd_next[k] = port_d_output_latch[k];
         end
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_d_read <= 4'h0;
      end else begin
         port_d_read <= port_rd_next;
      end
   end

   // ==========================================================
   // Duty register read-back
   // ==========================================================
   // Returns the written value, not the one in use this period.
   // Absent channel reads zero.
   always @* begin
      case (dm_rd_sel)
         2'h0: begin
            rd_data_next = ch_present[0] ? duty_reg[0] : 8'h00;
         end
         2'h1: begin
            rd_data_next = ch_present[1] ? duty_reg[1] : 8'h00;
         end
         2'h2: begin
            rd_data_next = ch_present[2] ? duty_reg[2] : 8'h00;
         end
         2'h3: begin
            rd_data_next = ch_present[3] ? duty_reg[3] : 8'h00;
         end
         default: begin
            rd_data_next = 8'h00;
         end
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dm_rd_data <= 8'h00;
      end else begin
         dm_rd_data <= rd_data_next;
      end
   end

endmodule // sdm_modulator

// File: sdm_modulator_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module sdm_modulator_chk #(
   parameter       NUM_CH   = 4,
   parameter       SUB4     = 1,
   parameter [3:0] PULL_OPT = 4'hF
) (
   input wire       mclk,
   input wire       rst_n,
   input wire       dm_wr_en,
   input wire [1:0] dm_wr_sel,
   input wire [1:0] dm_rd_sel,
   input wire [7:0] dm_rd_data,
   input wire [3:0] port_d_direction,
   input wire [3:0] port_d_output_latch,
   input wire [3:0] shared_pin_out,
   input wire [3:0] shared_pin_oe,
   input wire [3:0] shared_pin_pull,
   input wire [3:0] duty_pending,
   input wire       period_start
);
   // Phase seen at the pins, zero in the period_start cycle
   reg  [7:0] pos_reg;
   wire [7:0] pos_next = period_start ? 8'h01 : pos_reg + 8'h01;
   wire       at_edge  = SUB4 ? (pos_reg[5:0] == 6'h00) : (pos_reg[6:0] == 7'h00);
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pos_reg <= 8'hFF;
      end else begin
         pos_reg <= pos_next;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Properties
   property p_period; period_start |-> ##256 period_start; endproperty
   property p_single; period_start |=> !period_start [*8]; endproperty
   property p_oe; 1'b1 |=> (shared_pin_oe == ~$past(port_d_direction)); endproperty
   property p_pull; 1'b1 |=> (shared_pin_pull == ($past(port_d_direction) & PULL_OPT)); endproperty
   property p_low; 1'b1 |=> ((shared_pin_out & ~$past(port_d_output_latch)) == 4'h0); endproperty
   property p_pend_set;
      dm_wr_en && (dm_wr_sel < NUM_CH) |=> duty_pending[$past(dm_wr_sel)];
   endproperty
   property p_pend_clr;
      period_start && !$past(dm_wr_en, 2) |-> ($past(duty_pending) == 4'h0);
   endproperty
   property p_rd_absent; (dm_rd_sel >= NUM_CH) |=> (dm_rd_data == 8'h00); endproperty
   // Rises caused by latch or direction changes are left out
   property p_high_first;
      ((shared_pin_out & ~$past(shared_pin_out)
        & ~($past(port_d_output_latch) ^ $past(port_d_output_latch, 2))
        & ~($past(port_d_direction) ^ $past(port_d_direction, 2))) != 4'h0) |-> at_edge;
   endproperty
   a_period: assert property (p_period) else $error("period length wrong");
   a_single: assert property (p_single) else $error("period pulse too long");
   a_oe: assert property (p_oe) else $error("pin drive enable wrong");
   a_pull: assert property (p_pull) else $error("pull-high wrong");
   a_low: assert property (p_low) else $error("pin high with latch low");
   a_pend_set: assert property (p_pend_set) else $error("pending not set");
   a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
   a_rd_absent: assert property (p_rd_absent) else $error("absent channel read");
   a_high_first: assert property (p_high_first) else $error("rise inside sub-cycle");
   c_wave: cover property (period_start && (shared_pin_out != 4'h0));
   c_pend: cover property ((duty_pending != 4'h0) ##1 (duty_pending == 4'h0));
   c_absent: cover property (dm_wr_en && (dm_wr_sel >= NUM_CH));
endmodule // sdm_modulator_chk

bind sdm_modulator sdm_modulator_chk #(
   .NUM_CH(NUM_CH), .SUB4(SUB4), .PULL_OPT(PULL_OPT)
) u_chk (
   .mclk(mclk), .rst_n(rst_n), .dm_wr_en(dm_wr_en), .dm_wr_sel(dm_wr_sel),
   .dm_rd_sel(dm_rd_sel), .dm_rd_data(dm_rd_data), .port_d_direction(port_d_direction),
   .port_d_output_latch(port_d_output_latch), .shared_pin_out(shared_pin_out),
   .shared_pin_oe(shared_pin_oe), .shared_pin_pull(shared_pin_pull),
   .duty_pending(duty_pending), .period_start(period_start)
);

// File: sdm_pin_load.sv
`timescale 1ns/1ps
// ==========================================================
// Load on the shared pins
module sdm_pin_load (
   input  wire       mclk,
   input  wire [3:0] pin_out,
   input  wire [3:0] pin_oe,
   input  wire [3:0] pin_pull,
   output wire [3:0] pad
);
   // Undriven pin without pull wanders, so no stale level reads back
   reg [3:0] float_reg = 4'h5;
   always @(posedge mclk) begin
      float_reg <= ~float_reg;
   end
   assign pad = (pin_oe & pin_out) | (~pin_oe & (pin_pull | float_reg));
endmodule // sdm_pin_load

// File: sdm_modulator_tb_top.sv
`timescale 1ns/1ps
module sdm_modulator_tb_top;
   logic       mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0;
   logic [1:0] wr_sel = 2'h0, rd_sel = 2'h0;
   logic [7:0] wr_data = 8'h00, rd_a, rd_b;
   logic [3:0] dir = 4'hF, lat = 4'h0;
   logic [3:0] out_a, oe_a, pul_a, prd_a, pnd_a, pad_a;
   logic [3:0] out_b, oe_b, pul_b, prd_b, pnd_b, pad_b;
   logic       ps_a, ps_b;
   logic [7:0] duty [4] = '{default: 8'h00};
   logic [7:0] newd [4];
   int         bad_count = 0;
   int         compares = 0;
   initial begin
      forever #25 mclk = ~mclk;
   end
   // ==========================================================
   // Two builds: four 64-clock and three-channel 128-clock
   sdm_modulator #(.NUM_CH(4), .SUB4(1)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .dm_wr_en(wr_en), .dm_wr_sel(wr_sel), .dm_wr_data(wr_data),
      .dm_rd_sel(rd_sel), .dm_rd_data(rd_a), .port_d_direction(dir), .port_d_output_latch(lat),
      .shared_pin_in(pad_a), .shared_pin_out(out_a), .shared_pin_oe(oe_a),
      .shared_pin_pull(pul_a), .port_d_read(prd_a), .duty_pending(pnd_a), .period_start(ps_a));
   sdm_modulator #(.NUM_CH(3), .SUB4(0)) u_dut2 (
      .mclk(mclk), .rst_n(rst_n), .dm_wr_en(wr_en), .dm_wr_sel(wr_sel), .dm_wr_data(wr_data),
      .dm_rd_sel(rd_sel), .dm_rd_data(rd_b), .port_d_direction(dir), .port_d_output_latch(lat),
      .shared_pin_in(pad_b), .shared_pin_out(out_b), .shared_pin_oe(oe_b),
      .shared_pin_pull(pul_b), .port_d_read(prd_b), .duty_pending(pnd_b), .period_start(ps_b));
   sdm_pin_load u_load_a (.mclk(mclk), .pin_out(out_a), .pin_oe(oe_a), .pin_pull(pul_a),
      .pad(pad_a));
   sdm_pin_load u_load_b (.mclk(mclk), .pin_out(out_b), .pin_oe(oe_b), .pin_pull(pul_b),
      .pad(pad_b));
   // ==========================================================
   // Tasks
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One full period sampled at every pin; optional writes in mid-period
   task automatic measure(input bit load);
      int         i, k;
      int         err_a [4];
      int         err_b [4];
      logic [7:0] hi;
      logic       ea, eb;
      err_a = '{default: 0};
      err_b = '{default: 0};
      for (i = 0; i < 300 && ps_a !== 1'b1; i++) @(negedge mclk);
      check("period_start", 8'h01, {7'h00, ps_a});
      for (i = 0; i < 256; i++) begin
         for (k = 0; k < 4; k++) begin
            hi = duty[k][7:2] + ((i[7:6] < duty[k][1:0]) ? 8'h01 : 8'h00);
            ea = lat[k] & ~dir[k] & (i[5:0] < hi);
            hi = duty[k][7:1] + ((i[7] == 1'b0 && duty[k][0]) ? 8'h01 : 8'h00);
            eb = lat[k] & ~dir[k] & ((k == 3) || (i[6:0] < hi));
            if (out_a[k] !== ea) err_a[k]++;
            if (out_b[k] !== eb) err_b[k]++;
         end
         if (load && i >= 20 && i < 24) begin
            wr_en = 1'b1;
            wr_sel = i[1:0];
            wr_data = newd[i - 20];
         end else begin
            wr_en = 1'b0;
         end
         if (i == 40) begin
            check("pending_a", load ? 8'h0F : 8'h00, {4'h0, pnd_a});
            check("pending_b", load ? 8'h07 : 8'h00, {4'h0, pnd_b});
            check("oe", {4'h0, ~dir}, {4'h0, oe_a});
            check("pull", {4'h0, dir}, {4'h0, pul_a});
            check("port_read", {4'h0, dir | lat}, {4'h0, prd_a});
            check("oe_b", {4'h0, ~dir}, {4'h0, oe_b});
            check("pull_b", {4'h0, dir}, {4'h0, pul_b});
            check("port_read_b", {4'h0, dir | lat}, {4'h0, prd_b});
         end
         @(negedge mclk);
      end
      for (k = 0; k < 4; k++) begin
         check("wave_four", 8'h00, (err_a[k] > 255) ? 8'hFF : err_a[k][7:0]);
         check("wave_two", 8'h00, (err_b[k] > 255) ? 8'hFF : err_b[k][7:0]);
      end
      if (load) duty = newd;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      int k;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
      check("oe_reset", 8'h00, {4'h0, oe_a});
      check("read_reset", 8'h0F, {4'h0, prd_a});
      dir = 4'h0;
      lat = 4'hF;
      newd = '{8'h05, 8'hFF, 8'h00, 8'h66};
      measure(1'b1);
      measure(1'b0);
      newd = '{8'h81, 8'h02, 8'hFE, 8'h03};
      measure(1'b1);
      measure(1'b0);
      lat = 4'h5;
      repeat (2) @(negedge mclk);
      measure(1'b0);
      dir = 4'hA;
      repeat (2) @(negedge mclk);
      measure(1'b0);
      for (k = 0; k < 4; k++) begin
         rd_sel = k[1:0];
         @(negedge mclk);
         check("read_a", duty[k], rd_a);
         check("read_b", (k < 3) ? duty[k] : 8'h00, rd_b);
      end
      stop_test();
   end
   initial begin
      #(50 * 20000);
      bad_count++;
      stop_test();
   end
endmodule // sdm_modulator_tb_top
